// *** verilog/dsl_pkg.sv ***
// Shared constants, types and state layout of the device security lock
package dsl_pkg;
    // Flash geometry: blocks of words
    localparam int BLK_W   = 3;
    localparam int WORD_W  = 4;
    localparam int ADDR_W  = BLK_W + WORD_W;
    localparam int NUM_BLK = 1 << BLK_W;
    localparam int DATA_W  = 8;
    // Latch geometry and vote threshold
    localparam int KEY_W    = 32;
    localparam int VOTE_MIN = 28;
    // Protection level width and codes, higher is stricter
    localparam int LVL_W = 2;
    localparam logic [LVL_W-1:0] LVL_NONE  = 2'h0;
    localparam logic [LVL_W-1:0] LVL_WRITE = 2'h1;
    localparam logic [LVL_W-1:0] LVL_FULL  = 2'h2;
    // Value left in a flash word by erase
    localparam logic [DATA_W-1:0] ERASED_WORD = 8'hFF;
    // Lock key pattern; arbitrary value, not any product's key
    localparam logic [KEY_W-1:0] KEY_PATTERN_DFLT = 32'hA5C3_3C5A;
    // Latch cell contents at power-on; arbitrary value
    localparam logic [KEY_W-1:0] NV_POWERUP_DFLT = 32'h0000_0000;

    // Debug-port operations
    typedef enum logic [3:0] {
        OP_NOP,
        OP_ERASE_ALL,
        OP_ERASE_BLK,
        OP_PROGRAM,
        OP_VERIFY,
        OP_RAISE_PROT,
        OP_KEY_LOAD,
        OP_KEY_COMMIT,
        OP_KEY_READ
    } dsl_op_e;

    // Answer codes
    typedef enum logic [2:0] {
        RS_OK,
        RS_LOCKED,
        RS_PROT,
        RS_MISMATCH,
        RS_BAD
    } dsl_rsp_e;

    // Sequencer states
    typedef enum logic [1:0] {
        S_IDLE,
        S_ERASE,
        S_VERIFY
    } dsl_fsm_e;

    // One request from the debug port
    typedef struct packed {
        dsl_op_e                op;
        logic                   via_swd;
        logic [BLK_W-1:0]       blk;
        logic [WORD_W-1:0]      word;
        logic [KEY_W-1:0]       data;
    } dsl_cmd_s;

    // One answer to the debug port
    typedef struct packed {
        dsl_rsp_e               status;
        logic [KEY_W-1:0]       data;
    } dsl_rsp_s;

    // All state of the lock block
    typedef struct packed {
        dsl_fsm_e                          fsm;
        dsl_cmd_s                          cur;
        logic [ADDR_W-1:0]                 ptr;
        logic                              erase_all;
        logic                              locked;
        logic                              vote;
        logic [NUM_BLK-1:0][LVL_W-1:0]     prot;
        logic [KEY_W-1:0]                  key_stage;
        logic                              staged;
        logic [KEY_W-1:0]                  nv_cells;
        logic                              busy;
        logic                              rsp_valid;
        dsl_rsp_s                          rsp;
    } dsl_state_s;
endpackage : dsl_pkg

// *** verilog/dsl_mem.sv ***
// Flash word array with registered read data
`timescale 1ns/1ns
module dsl_mem #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata
);
    // Array is not reset: flash contents survive a device reset
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // Write port and registered read, frozen while ce is low
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata <= '0;
        end else if (ce) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule : dsl_mem

// *** verilog/dsl_lock.sv ***
// Device security lock: flash program, protection and key latch, frozen once it votes locked
//
// Operation
// R1: Erase, program, verify whole device via either port
// R2: Levels only rise; full erase clears them; code also clears them at power-on reset
// R3: Block operations obey that block's protection level
// R4: Programmer writes the fixed 32-bit key
// R5: Latch holds 32 nonvolatile bits; code reloads NV_POWERUP at power-on unless the cells vote locked
// R6: Wrapper outputs 1 when 28+ bits match
// R7: Vote high blocks debug, test, latch changes
// R8: Lock needs load, commit, then reset
// R9: Vote sampled only at reset gates access
// R10: Key commit only while no protection set
// R11: Access stays granted until next reset
// R12: Programmer writes key, protection, then resets
// R13: Latch contents readable through the serial-wire port
// R14: Sampled lock decision held until next reset
`timescale 1ns/1ns
module dsl_lock #(
    parameter logic [dsl_pkg::KEY_W-1:0] KEY_PATTERN = dsl_pkg::KEY_PATTERN_DFLT,
    parameter logic [dsl_pkg::KEY_W-1:0] NV_POWERUP  = dsl_pkg::NV_POWERUP_DFLT
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              por_rst,
    input  wire logic              ce,
    input  wire logic              cmd_valid,
    input  wire dsl_pkg::dsl_cmd_s cmd,
    output logic                   cmd_ready,
    output logic                   rsp_valid,
    output dsl_pkg::dsl_rsp_s      rsp,
    output logic                   dev_locked,
    output logic                   latch_vote,
    output logic                   debug_en,
    output logic                   test_en
);
    // Registered state and its next value
    dsl_pkg::dsl_state_s st;
    dsl_pkg::dsl_state_s next_st;

    // Flash array port, driven by the sequencer
    logic                          mem_we;
    logic [dsl_pkg::ADDR_W-1:0]    mem_addr;
    logic [dsl_pkg::DATA_W-1:0]    mem_wdata;
    logic [dsl_pkg::DATA_W-1:0]    mem_rdata;

    // Request decode helpers
    logic [dsl_pkg::ADDR_W-1:0]    req_addr;
    logic [dsl_pkg::LVL_W-1:0]     req_lvl;
    logic [dsl_pkg::LVL_W-1:0]     blk_lvl;
    logic                          erase_last;

    // R6: super-majority vote
    // Tolerates a few failed cells so that a worn bit cannot unlock a part
    function automatic logic vote_match(
        input logic [dsl_pkg::KEY_W-1:0] cells,
        input logic [dsl_pkg::KEY_W-1:0] pattern
    );
        int cnt;
        cnt = 0;
        for (int i = 0; i < dsl_pkg::KEY_W; i++) begin
            if (cells[i] == pattern[i]) begin
                cnt = cnt + 1;
            end
        end
        return (cnt >= dsl_pkg::VOTE_MIN);
    endfunction : vote_match

    // Reset value; nonvolatile fields survive a device reset
    function automatic dsl_pkg::dsl_state_s reset_state(
        input dsl_pkg::dsl_state_s s,
        input logic                por
    );
        dsl_pkg::dsl_state_s r;
        r = '0;
        r.fsm        = dsl_pkg::S_IDLE;
        r.cur.op     = dsl_pkg::OP_NOP;
        r.rsp.status = dsl_pkg::RS_OK;
        // R5 R7: 32 cells; a locked latch survives power-on
        r.nv_cells   = (por && !vote_match(s.nv_cells, KEY_PATTERN)) ? NV_POWERUP : s.nv_cells;
        r.prot       = por ? '0 : s.prot;
        // R9: wrapper output sampled at reset
        r.locked     = vote_match(r.nv_cells, KEY_PATTERN);
        r.vote       = r.locked;
        return r;
    endfunction : reset_state

    // Flash word storage
    dsl_mem #(
        .DATA_W (dsl_pkg::DATA_W),
        .ADDR_W (dsl_pkg::ADDR_W)
    ) u_mem (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .we      (mem_we),
        .addr    (mem_addr),
        .wdata   (mem_wdata),
        .rdata   (mem_rdata)
    );

    // Decode of the current request
    always_comb begin
        req_addr   = {cmd.blk, cmd.word};
        req_lvl    = cmd.data[dsl_pkg::LVL_W-1:0];
        blk_lvl    = st.prot[cmd.blk];
        // Last word of the erase sweep, whole array or one block
        erase_last = st.erase_all ? (&st.ptr) : (&st.ptr[dsl_pkg::WORD_W-1:0]);
    end

    // Next-state logic of the sequencer, protection and latch
    always_comb begin
        next_st           = st;
        next_st.rsp_valid = 1'b0;
        mem_we            = 1'b0;
        mem_addr          = st.ptr;
        mem_wdata         = dsl_pkg::ERASED_WORD;
        // R6: live wrapper output follows the cells
        next_st.vote      = vote_match(st.nv_cells, KEY_PATTERN);
        case (st.fsm)
            dsl_pkg::S_IDLE: begin
                if (cmd_valid && !st.busy) begin
                    next_st.cur        = cmd;
                    next_st.rsp.status = dsl_pkg::RS_OK;
                    next_st.rsp.data   = '0;
                    // R9: sampled lock refuses all but the latch readout
                    if (st.locked && !(cmd.op == dsl_pkg::OP_KEY_READ && cmd.via_swd)) begin
                        next_st.rsp.status = dsl_pkg::RS_LOCKED;
                        next_st.rsp_valid  = 1'b1;
                    end else begin
                        case (cmd.op)
                            // R1: whole device erase sweep
                            dsl_pkg::OP_ERASE_ALL: begin
                                next_st.fsm       = dsl_pkg::S_ERASE;
                                next_st.erase_all = 1'b1;
                                next_st.ptr       = '0;
                            end
                            // R3: block erase needs an open block
                            dsl_pkg::OP_ERASE_BLK: begin
                                if (blk_lvl != dsl_pkg::LVL_NONE) begin
                                    next_st.rsp.status = dsl_pkg::RS_PROT;
                                    next_st.rsp_valid  = 1'b1;
                                end else begin
                                    next_st.fsm       = dsl_pkg::S_ERASE;
                                    next_st.erase_all = 1'b0;
                                    next_st.ptr       = {cmd.blk, {dsl_pkg::WORD_W{1'b0}}};
                                end
                            end
                            // R3: program only an open block
                            dsl_pkg::OP_PROGRAM: begin
                                if (blk_lvl != dsl_pkg::LVL_NONE) begin
                                    next_st.rsp.status = dsl_pkg::RS_PROT;
                                end else begin
                                    mem_we    = ce;
                                    mem_addr  = req_addr;
                                    mem_wdata = cmd.data[dsl_pkg::DATA_W-1:0];
                                end
                                next_st.rsp_valid = 1'b1;
                            end
                            // R3: verify unless the block is read-protected
                            dsl_pkg::OP_VERIFY: begin
                                if (blk_lvl >= dsl_pkg::LVL_FULL) begin
                                    next_st.rsp.status = dsl_pkg::RS_PROT;
                                    next_st.rsp_valid  = 1'b1;
                                end else begin
                                    mem_addr    = req_addr;
                                    next_st.fsm = dsl_pkg::S_VERIFY;
                                end
                            end
                            // R2: a level may rise or stay, never fall
                            dsl_pkg::OP_RAISE_PROT: begin
                                if (req_lvl < blk_lvl) begin
                                    next_st.rsp.status = dsl_pkg::RS_PROT;
                                end else begin
                                    next_st.prot[cmd.blk] = req_lvl;
                                end
                                next_st.rsp_valid = 1'b1;
                            end
                            // R8: first step, key into the volatile stage
                            dsl_pkg::OP_KEY_LOAD: begin
                                // R7: frozen latch takes no new key
                                if (st.vote) begin
                                    next_st.rsp.status = dsl_pkg::RS_LOCKED;
                                end else begin
                                    next_st.key_stage = cmd.data;
                                    next_st.staged    = 1'b1;
                                end
                                next_st.rsp_valid = 1'b1;
                            end
                            // R8: second step, stage into the cells
                            dsl_pkg::OP_KEY_COMMIT: begin
                                // R7: frozen latch refuses alteration
                                if (st.vote) begin
                                    next_st.rsp.status = dsl_pkg::RS_LOCKED;
                                // R10: no commit while any level is set
                                end else if (|st.prot) begin
                                    next_st.rsp.status = dsl_pkg::RS_PROT;
                                end else if (!st.staged) begin
                                    next_st.rsp.status = dsl_pkg::RS_BAD;
                                end else begin
                                    // R11: lock register untouched until reset
                                    next_st.nv_cells = st.key_stage;
                                    next_st.staged   = 1'b0;
                                end
                                next_st.rsp_valid = 1'b1;
                            end
                            // R13: latch readout only over serial-wire
                            dsl_pkg::OP_KEY_READ: begin
                                if (cmd.via_swd) begin
                                    next_st.rsp.data = st.nv_cells;
                                end else begin
                                    next_st.rsp.status = dsl_pkg::RS_BAD;
                                end
                                next_st.rsp_valid = 1'b1;
                            end
                            // Unknown or empty operation
                            default: begin
                                next_st.rsp.status = dsl_pkg::RS_BAD;
                                next_st.rsp_valid  = 1'b1;
                            end
                        endcase
                    end
                end
            end
            // R1: one word erased per cycle
            dsl_pkg::S_ERASE: begin
                mem_we      = ce;
                mem_addr    = st.ptr;
                next_st.ptr = st.ptr + 1'h1;
                if (erase_last) begin
                    next_st.fsm       = dsl_pkg::S_IDLE;
                    next_st.rsp_valid = 1'b1;
                    // R2: of the two erases, only a full erase drops protection
                    if (st.erase_all) begin
                        next_st.prot = '0;
                    end
                end
            end
            // R1: compare the registered read with expected data
            dsl_pkg::S_VERIFY: begin
                next_st.rsp.data   = {{(dsl_pkg::KEY_W-dsl_pkg::DATA_W){1'b0}}, mem_rdata};
                next_st.rsp.status = (mem_rdata == st.cur.data[dsl_pkg::DATA_W-1:0]) ?
                                     dsl_pkg::RS_OK : dsl_pkg::RS_MISMATCH;
                next_st.rsp_valid  = 1'b1;
                next_st.fsm        = dsl_pkg::S_IDLE;
            end
            // Recover from an illegal code
            default: begin
                next_st.fsm = dsl_pkg::S_IDLE;
            end
        endcase
        next_st.busy = (next_st.fsm != dsl_pkg::S_IDLE);
    end

    // State register; resets take priority over the clock enable
    always_ff @(posedge sys_clk) begin
        if (por_rst || sys_rst) begin
            // R14: lock decision loaded here only
            st <= reset_state(st, por_rst);
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign cmd_ready  = ~st.busy;
    assign rsp_valid  = st.rsp_valid;
    assign rsp        = st.rsp;
    assign dev_locked = st.locked;
    assign latch_vote = st.vote;
    // R7: debug and test ports shut while locked
    assign debug_en   = ~st.locked;
    assign test_en    = ~st.locked;
endmodule : dsl_lock

// *** sim/dsl_lock_assertions.sv ***
// Port-level checks of the device security lock
`timescale 1ns/1ns
module dsl_lock_assertions #(
    parameter logic [dsl_pkg::KEY_W-1:0] KEY_PATTERN = dsl_pkg::KEY_PATTERN_DFLT
) (
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic              por_rst,
    input wire logic              ce,
    input wire logic              cmd_valid,
    input wire dsl_pkg::dsl_cmd_s cmd,
    input wire logic              cmd_ready,
    input wire logic              rsp_valid,
    input wire dsl_pkg::dsl_rsp_s rsp,
    input wire logic              dev_locked,
    input wire logic              latch_vote,
    input wire logic              debug_en,
    input wire logic              test_en
);
    logic                         take;     // Request accepted this edge
    dsl_pkg::dsl_cmd_s            last;     // Last accepted request
    logic [dsl_pkg::KEY_W-1:0]    key_q;    // Last key offered
    logic [3:0]                   run_cnt;  // Cycles since reset, saturating
    assign take = cmd_valid && cmd_ready && ce;
    // Track requests and reset age
    always_ff @(posedge sys_clk) begin
        if (take) last <= cmd;
        if (take && cmd.op == dsl_pkg::OP_KEY_LOAD) key_q <= cmd.data;
        if (sys_rst || por_rst) run_cnt <= 4'h0;
        else if (run_cnt != 4'hF) run_cnt <= run_cnt + 4'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst || por_rst);
    sequence s_take(dsl_pkg::dsl_op_e o);
        take && cmd.op == o;
    endsequence
    sequence s_refused;
        rsp_valid && rsp.status != dsl_pkg::RS_OK;
    endsequence
    a_debug_gated: assert property (debug_en != dev_locked && test_en != dev_locked)
        else $error("debug/test not gated");
    a_lock_held: assert property (run_cnt > 4'h1 |-> $stable(dev_locked))
        else $error("lock changed");
    a_locked_refuse: assert property (rsp_valid && dev_locked && !(last.via_swd
        && last.op == dsl_pkg::OP_KEY_READ) |-> rsp.status == dsl_pkg::RS_LOCKED)
        else $error("locked not refused");
    a_short_answer: assert property (take && !(cmd.op inside {dsl_pkg::OP_VERIFY,
        dsl_pkg::OP_ERASE_BLK, dsl_pkg::OP_ERASE_ALL}) |=> rsp_valid)
        else $error("short answer late");
    a_verify_time: assert property (s_take(dsl_pkg::OP_VERIFY) |=> s_refused
        or (!rsp_valid ##1 rsp_valid)) else $error("verify late");
    a_erase_blk_time: assert property (s_take(dsl_pkg::OP_ERASE_BLK) |=> s_refused
        or (!rsp_valid ##16 rsp_valid)) else $error("erase blk late");
    a_erase_all_time: assert property (s_take(dsl_pkg::OP_ERASE_ALL) |=> s_refused
        or (!rsp_valid ##128 rsp_valid)) else $error("erase all late");
    a_vote_follows: assert property (rsp_valid && rsp.status == dsl_pkg::RS_OK
        && last.op == dsl_pkg::OP_KEY_COMMIT |=> latch_vote ==
        ($countones(~(key_q ^ KEY_PATTERN)) >= dsl_pkg::VOTE_MIN))
        else $error("vote wrong");
    a_vote_frozen: assert property (latch_vote |=> latch_vote)
        else $error("latch vote dropped");
    a_reset_sample: assert property (@(posedge sys_clk) disable iff (por_rst)
        sys_rst [*3] |-> dev_locked == latch_vote) else $error("vote not sampled");
endmodule : dsl_lock_assertions

bind dsl_lock dsl_lock_assertions #(.KEY_PATTERN(KEY_PATTERN)) u_dsl_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .por_rst(por_rst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .dev_locked(dev_locked), .latch_vote(latch_vote),
    .debug_en(debug_en), .test_en(test_en));

// *** sim/dsl_prog_model.sv ***
// Programmer model: debug-port requests and answers
`timescale 1ns/1ns
module dsl_prog_model (
    input  wire logic              sys_clk,
    input  wire logic              cmd_ready,
    input  wire logic              rsp_valid,
    input  wire dsl_pkg::dsl_rsp_s rsp,
    output dsl_pkg::dsl_cmd_s      cmd,
    output logic                   cmd_valid
);
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end
    // hold request until taken; junk while idle
    task automatic xfer(input dsl_pkg::dsl_op_e op, input logic swd, input logic [6:0] ad,
                        input logic [31:0] dt, input int gap,
                        output dsl_pkg::dsl_rsp_s r, output logic ok);
        int n;
        n = 0;
        repeat (gap) @(negedge sys_clk) cmd = dsl_pkg::dsl_cmd_s'(~cmd);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd = '{op, swd, ad[6:4], ad[3:0], dt};
        // Bounded wait
        while (!cmd_ready && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        cmd = dsl_pkg::dsl_cmd_s'(~cmd);
        while (!rsp_valid && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        r = rsp;
        ok = rsp_valid;
    endtask : xfer
endmodule : dsl_prog_model

// *** sim/tb_top.sv ***
// Self-checking bench of the security lock
`timescale 1ns/1ns
module tb_top;
    logic              sys_clk, sys_rst, por_rst, ce, cmd_valid, cmd_ready, rsp_valid;
    logic              dev_locked, latch_vote, debug_en, test_en;
    dsl_pkg::dsl_cmd_s cmd;
    dsl_pkg::dsl_rsp_s rsp;
    int                mem [128];   // Model flash words
    int                lvl [8];     // Model block levels
    logic [31:0]       cells, stg;  // Model latch cells and stage
    logic              staged, mlock;
    logic [31:0]       rng = 32'h979C5524;
    int                n_mismatch = 0, n_compared = 0, cyc = 0, a;
    logic [31:0]       d;
    dsl_lock dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .por_rst(por_rst), .ce(ce),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp(rsp), .dev_locked(dev_locked), .latch_vote(latch_vote), .debug_en(debug_en),
        .test_en(test_en));
    dsl_prog_model prog (.sys_clk(sys_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp(rsp), .cmd(cmd), .cmd_valid(cmd_valid));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Hang guard above run length
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            $display("MISMATCH %0t timeout", $time);
            final_report();
        end
    end
    function automatic logic [31:0] nxt();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : nxt
    function automatic logic vote(input logic [31:0] c);
        return $countones(~(c ^ dsl_pkg::KEY_PATTERN_DFLT)) >= dsl_pkg::VOTE_MIN;
    endfunction : vote
    task automatic chk_rsp(input dsl_pkg::dsl_rsp_e es, input logic [31:0] ed,
                           input logic dm, input dsl_pkg::dsl_rsp_s g);
        n_compared++;
        if (g.status !== es || (dm && g.data !== ed)) begin
            n_mismatch++;
            $display("MISMATCH %0t rsp want %0d %h got %0d %h", $time, es, ed, g.status, g.data);
        end
    endtask : chk_rsp
    task automatic chk_bit(input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %0t flag want %b got %b", $time, e, g);
        end
    endtask : chk_bit
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // 20-cycle reset, then check sampled decision
    task automatic do_reset(input logic por);
        @(negedge sys_clk);
        sys_rst = 1'b1;
        por_rst = por;
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        por_rst = 1'b0;
        if (por) begin
            if (!vote(cells)) cells = dsl_pkg::NV_POWERUP_DFLT;
            lvl = '{default: 0};
        end
        staged = 1'b0;
        mlock = vote(cells);
        @(negedge sys_clk);
        chk_bit(mlock, dev_locked);
        chk_bit(!mlock, debug_en);
        chk_bit(!mlock, test_en);
        chk_bit(mlock, latch_vote);
    endtask : do_reset
    // Model, issue and compare one request
    task automatic run(input dsl_pkg::dsl_op_e op, input logic swd, input int ad,
                       input logic [31:0] dt);
        dsl_pkg::dsl_rsp_e st;
        dsl_pkg::dsl_rsp_s r;
        logic [31:0]       ed;
        logic              ok;
        int                b;
        b = ad / 16;
        st = dsl_pkg::RS_OK;
        ed = 32'h0;
        if (mlock && !(op == dsl_pkg::OP_KEY_READ && swd)) st = dsl_pkg::RS_LOCKED;
        else case (op)
            dsl_pkg::OP_ERASE_ALL: begin
                mem = '{default: 255};
                lvl = '{default: 0};
            end
            dsl_pkg::OP_ERASE_BLK: if (lvl[b] != 0) st = dsl_pkg::RS_PROT;
                else for (int i = 0; i < 16; i++) mem[b*16+i] = 255;
            dsl_pkg::OP_PROGRAM: if (lvl[b] != 0) st = dsl_pkg::RS_PROT;
                else mem[ad] = int'(dt[7:0]);
            dsl_pkg::OP_VERIFY: if (lvl[b] >= 2) st = dsl_pkg::RS_PROT;
                else begin
                    ed = 32'(mem[ad]);
                    if (mem[ad] != int'(dt[7:0])) st = dsl_pkg::RS_MISMATCH;
                end
            dsl_pkg::OP_RAISE_PROT: if (int'(dt[1:0]) < lvl[b]) st = dsl_pkg::RS_PROT;
                else lvl[b] = int'(dt[1:0]);
            dsl_pkg::OP_KEY_LOAD: if (vote(cells)) st = dsl_pkg::RS_LOCKED;
                else begin
                    stg = dt;
                    staged = 1'b1;
                end
            dsl_pkg::OP_KEY_COMMIT: if (vote(cells)) st = dsl_pkg::RS_LOCKED;
                else if (lvl.sum() != 0) st = dsl_pkg::RS_PROT;
                else if (!staged) st = dsl_pkg::RS_BAD;
                else begin
                    cells = stg;
                    staged = 1'b0;
                end
            dsl_pkg::OP_KEY_READ: if (swd) ed = cells; else st = dsl_pkg::RS_BAD;
            default: st = dsl_pkg::RS_BAD;
        endcase
        prog.xfer(op, swd, ad[6:0], dt, int'(nxt() & 32'h3), r, ok);
        chk_bit(1'b1, ok);
        chk_rsp(st, ed, op inside {dsl_pkg::OP_VERIFY, dsl_pkg::OP_KEY_READ} &&
            st inside {dsl_pkg::RS_OK, dsl_pkg::RS_MISMATCH}, r);
    endtask : run
    initial begin
        sys_rst = 1'b1;
        por_rst = 1'b1;
        ce = 1'b1;
        do_reset(1'b1);
        run(dsl_pkg::OP_ERASE_ALL, 1'b0, 0, 32'h0);
        for (int i = 0; i < 24; i++) begin
            a = int'(nxt() & 32'h7F);
            d = nxt();
            run(dsl_pkg::OP_PROGRAM, d[31], a, d);
            run(dsl_pkg::OP_VERIFY, !d[31], a, d ^ 32'(i % 2));
        end
        run(dsl_pkg::OP_RAISE_PROT, 1'b1, 32, 32'h1);
        run(dsl_pkg::OP_PROGRAM, 1'b0, 33, 32'h12);
        run(dsl_pkg::OP_ERASE_BLK, 1'b0, 32, 32'h0);
        run(dsl_pkg::OP_VERIFY, 1'b0, 33, 32'h12);
        for (int k = 0; k < 3; k++) run(dsl_pkg::OP_RAISE_PROT, 1'b0, 32, 32'(k));
        run(dsl_pkg::OP_VERIFY, 1'b0, 33, 32'h12);
        run(dsl_pkg::OP_ERASE_BLK, 1'b1, 48, 32'h0);
        run(dsl_pkg::OP_VERIFY, 1'b1, 50, 32'hFF);
        run(dsl_pkg::OP_KEY_LOAD, 1'b1, 0, dsl_pkg::KEY_PATTERN_DFLT);
        run(dsl_pkg::OP_KEY_COMMIT, 1'b1, 0, 32'h0);
        run(dsl_pkg::OP_ERASE_ALL, 1'b1, 0, 32'h0);
        run(dsl_pkg::OP_PROGRAM, 1'b0, 33, 32'h5A);
        run(dsl_pkg::OP_NOP, 1'b0, 0, 32'h0);
        run(dsl_pkg::OP_KEY_READ, 1'b0, 0, 32'h0);
        run(dsl_pkg::dsl_op_e'(4'hF), 1'b0, 0, 32'h0);
        do_reset(1'b0);
        run(dsl_pkg::OP_KEY_COMMIT, 1'b0, 0, 32'h0);
        run(dsl_pkg::OP_KEY_LOAD, 1'b0, 0, dsl_pkg::KEY_PATTERN_DFLT ^ 32'h1F);
        run(dsl_pkg::OP_KEY_COMMIT, 1'b0, 0, 32'h0);
        do_reset(1'b0);
        run(dsl_pkg::OP_KEY_READ, 1'b1, 0, 32'h0);
        run(dsl_pkg::OP_KEY_LOAD, 1'b0, 0, dsl_pkg::KEY_PATTERN_DFLT ^ 32'h0F);
        run(dsl_pkg::OP_KEY_COMMIT, 1'b0, 0, 32'h0);
        @(negedge sys_clk);
        chk_bit(1'b1, latch_vote);
        chk_bit(1'b0, dev_locked);
        run(dsl_pkg::OP_PROGRAM, 1'b1, 5, 32'h33);
        run(dsl_pkg::OP_KEY_LOAD, 1'b0, 0, dsl_pkg::KEY_PATTERN_DFLT);
        run(dsl_pkg::OP_RAISE_PROT, 1'b0, 0, 32'h3);
        do_reset(1'b0);
        for (int k = 0; k < 9; k++) run(dsl_pkg::dsl_op_e'(k), 1'b0, 5, 32'h33);
        run(dsl_pkg::OP_KEY_READ, 1'b1, 0, 32'h0);
        do_reset(1'b1);
        run(dsl_pkg::OP_VERIFY, 1'b1, 5, 32'h33);
        final_report();
    end
endmodule : tb_top
